// ### fpsd_defines.vh
// Purpose: constants for the front panel status display selector
// Assumes: 100 MHz core clock, APB register access, 32-bit data
// Notes:   offsets are register indices; byte address is four times the index
// Overview of operation
// R01: A selection register picks which item is shown on the two-digit display.
// R02: Selection 0 shows a servo-off pattern while the servo is off and 00 while it is on.
// R03: Selection 1 shows the 8-bit mechanical angle that wraps from FF to 0.
// R04: With an incremental encoder the mechanical angle shows a not-fixed pattern until zero is found.
// R05: Selection 2 shows the 8-bit electrical angle that wraps from FF to 0.
// R06: Fieldbus, encoder and external encoder error counts are 16 bits and saturate at FFFF.
// R07: An error-count selection shows only the low byte of its counter.
// R08: Error counters clear only at power-on reset and are kept otherwise.
// R09: Selection 4 shows in decimal the node address caught once at power-on.
// R10: Selection 7 shows the 8-bit Z-phase count of an incremental external encoder.
// R11: The Z-phase count is shown as read, ignoring the feedback direction setting.
// R12: Software must not program selection codes of 8 or higher.
// R13: The node address is shown after power-on for a time in 100 ms steps, 0 to 1000.
// R14: A one-bit setting picks the torque-limit flag condition in torque control.
// R15: Setting 0 compares the limit with the torque command, setting 1 without it.
// R16: After the address time the display follows the current selection continuously.
`ifndef FPSD_DEFINES_VH
`define FPSD_DEFINES_VH

`define FPSD_IDX_DISP_SEL     16'h3700
`define FPSD_IDX_SHOW_TIME    16'h3701
`define FPSD_IDX_TLIM_COND    16'h3703
`define FPSD_IDX_ERR_FB       16'h3710
`define FPSD_IDX_ERR_ENC      16'h3711
`define FPSD_IDX_ERR_EXT      16'h3712
`define FPSD_IDX_STATUS       16'h3713

`define FPSD_RST_DISP_SEL     16'h0000
`define FPSD_RST_SHOW_TIME    16'h0000
`define FPSD_RST_TLIM_COND    16'h0000
`define FPSD_SHOW_TIME_MAX    16'h03E8
`define FPSD_SEL_UNUSED_MIN   16'h0008

`define FPSD_SEL_NORMAL       3'h0
`define FPSD_SEL_MECH         3'h1
`define FPSD_SEL_ELEC         3'h2
`define FPSD_SEL_ERR_FB       3'h3
`define FPSD_SEL_NODE         3'h4
`define FPSD_SEL_ERR_ENC      3'h5
`define FPSD_SEL_ERR_EXT      3'h6
`define FPSD_SEL_ZPHASE       3'h7

`define FPSD_STAT_ADDR_SHOW   8
`define FPSD_STAT_ZERO_FOUND  9

`define FPSD_SEG_DASH         7'h40
`define FPSD_SEG_N            7'h54
`define FPSD_SEG_F            7'h71

`define FPSD_CLK_HZ           100000000
`define FPSD_SHOW_STEP_MS     100
`define FPSD_SHOW_STEP_CYC    ((`FPSD_CLK_HZ / 1000) * `FPSD_SHOW_STEP_MS)
`define FPSD_ROT_CAPTURE_CYC  2'h2

`endif

// ### fpsd_sat_cnt.v
// Purpose: saturating event counter
// Assumes: inc_i is a one-cycle pulse on the core clock
// Notes:   cleared only by the power-on reset
`default_nettype none
module fpsd_sat_cnt #(
	parameter WIDTH = 16
) (
	input  wire             core_clk_i,
	input  wire             rst_i,
	input  wire             inc_i,
	output wire [WIDTH-1:0] count_o
);
	reg [WIDTH-1:0] count_ff;
	reg [WIDTH-1:0] nxt_count;

	always @* begin
		nxt_count = count_ff;
		if (inc_i && (count_ff != {WIDTH{1'b1}})) begin // see R06
			nxt_count = count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge core_clk_i) begin
		if (rst_i) begin // see R08
			count_ff <= {WIDTH{1'b0}};
		end else begin
			count_ff <= nxt_count;
		end
	end

	assign count_o = count_ff;
endmodule // fpsd_sat_cnt
`default_nettype wire

// ### fpsd_top.v
// Purpose: front panel two-digit display selector with APB registers
// Assumes: angle, error and torque inputs come from core-clock logic
// Notes:   segment bits are gfedcba, active high
`include "fpsd_defines.vh"
`default_nettype none
module fpsd_top #(
	parameter STEP_CYCLES = `FPSD_SHOW_STEP_CYC,
	parameter TICK_W      = 24,
	parameter CNT_W       = 16
) (
	input  wire        core_clk_i,
	input  wire        rst_i,
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [31:0] paddr_i,
	input  wire [31:0] pwdata_i,
	input  wire [3:0]  pstrb_i,
	output wire        pready_o,
	output wire        pslverr_o,
	output wire [31:0] prdata_o,
	input  wire        servo_on_i,
	input  wire [7:0]  mech_angle_i,
	input  wire [7:0]  elec_angle_i,
	input  wire        enc_incremental_i,
	input  wire        enc_zero_det_i,
	input  wire        fieldbus_err_i,
	input  wire        enc_comm_err_i,
	input  wire        ext_enc_comm_err_i,
	input  wire [7:0]  rotary_addr_i,
	input  wire        ext_incr_full_closed_i,
	input  wire [7:0]  zphase_cnt_i,
	input  wire        torque_ctrl_i,
	input  wire        tlim_incl_cmd_i,
	input  wire        tlim_excl_cmd_i,
	output wire [6:0]  seg_hi_o,
	output wire [6:0]  seg_lo_o,
	output wire        addr_show_o,
	output wire        torque_limit_flag_o
);
	localparam integer      STEP_LAST_I = STEP_CYCLES - 1;
	localparam [TICK_W-1:0] STEP_LAST   = STEP_LAST_I[TICK_W-1:0];

	// register hit for a given word index
	function addr_hit;
		input [31:0] addr;
		input [15:0] idx;
		begin
			addr_hit = (addr == {14'h0000, idx, 2'b00});
		end
	endfunction

	// hex digit to segments
	function [6:0] seg_hex;
		input [3:0] d;
		begin
			case (d)
				4'h0: seg_hex = 7'h3F;
				4'h1: seg_hex = 7'h06;
				4'h2: seg_hex = 7'h5B;
				4'h3: seg_hex = 7'h4F;
				4'h4: seg_hex = 7'h66;
				4'h5: seg_hex = 7'h6D;
				4'h6: seg_hex = 7'h7D;
				4'h7: seg_hex = 7'h07;
				4'h8: seg_hex = 7'h7F;
				4'h9: seg_hex = 7'h6F;
				4'hA: seg_hex = 7'h77;
				4'hB: seg_hex = 7'h7C;
				4'hC: seg_hex = 7'h39;
				4'hD: seg_hex = 7'h5E;
				4'hE: seg_hex = 7'h79;
				default: seg_hex = 7'h71;
			endcase
		end
	endfunction

	// masked 16-bit write merge
	function [15:0] wr_merge;
		input [15:0] old;
		input [31:0] wd;
		input [3:0]  strb;
		begin
			wr_merge[7:0]  = strb[0] ? wd[7:0] : old[7:0];
			wr_merge[15:8] = strb[1] ? wd[15:8] : old[15:8];
		end
	endfunction

	// apb registers
	reg  [15:0]     disp_sel_ff;
	reg  [15:0]     show_time_ff;
	reg             tlim_cond_ff;
	reg  [31:0]     prdata_ff;
	reg  [31:0]     nxt_prdata;
	reg             perr_ff;
	reg             nxt_perr;
	wire [15:0]     show_time_wr;
	wire            setup_ph;
	wire            wr_en;
	wire [CNT_W-1:0] err_fb_cnt;
	wire [CNT_W-1:0] err_enc_cnt;
	wire [CNT_W-1:0] err_ext_cnt;
	wire [2:0]       err_inc;
	wire [3*CNT_W-1:0] err_cnt;
	genvar           gi;

	// display state
	reg  [7:0]      rot_s1_ff;
	reg  [7:0]      rot_s2_ff;
	reg  [1:0]      rot_cap_ff;
	reg  [7:0]      node_addr_ff;
	reg             zero_found_ff;
	reg  [TICK_W-1:0] tick_cnt_ff;
	reg  [10:0]     elapsed_ff;
	reg             show_done_ff;
	wire            step_tick;
	wire            addr_show_act;
	reg  [6:0]      seg_hi_ff;
	reg  [6:0]      seg_lo_ff;
	reg  [6:0]      nxt_seg_hi;
	reg  [6:0]      nxt_seg_lo;
	wire [7:0]      dec_ones;
	wire [7:0]      dec_tens;
	reg             tflag_ff;

	assign setup_ph = psel_i && !penable_i;
	assign wr_en    = psel_i && penable_i && pwrite_i;
	assign pready_o = 1'b1;
	assign pslverr_o = perr_ff && psel_i && penable_i;
	assign prdata_o = prdata_ff;

	assign show_time_wr = wr_merge(show_time_ff, pwdata_i, pstrb_i);

	// read data and error are prepared in the setup cycle
	always @* begin
		nxt_prdata = 32'h0000_0000;
		nxt_perr   = 1'b0;
		if (addr_hit(paddr_i, `FPSD_IDX_DISP_SEL)) begin
			nxt_prdata[15:0] = disp_sel_ff;
		end else if (addr_hit(paddr_i, `FPSD_IDX_SHOW_TIME)) begin
			nxt_prdata[15:0] = show_time_ff;
		end else if (addr_hit(paddr_i, `FPSD_IDX_TLIM_COND)) begin
			nxt_prdata[0] = tlim_cond_ff;
		end else if (addr_hit(paddr_i, `FPSD_IDX_ERR_FB)) begin
			nxt_prdata[CNT_W-1:0] = err_fb_cnt;
			nxt_perr = pwrite_i;
		end else if (addr_hit(paddr_i, `FPSD_IDX_ERR_ENC)) begin
			nxt_prdata[CNT_W-1:0] = err_enc_cnt;
			nxt_perr = pwrite_i;
		end else if (addr_hit(paddr_i, `FPSD_IDX_ERR_EXT)) begin
			nxt_prdata[CNT_W-1:0] = err_ext_cnt;
			nxt_perr = pwrite_i;
		end else if (addr_hit(paddr_i, `FPSD_IDX_STATUS)) begin
			nxt_prdata[7:0] = node_addr_ff;
			nxt_prdata[`FPSD_STAT_ADDR_SHOW] = addr_show_act;
			nxt_prdata[`FPSD_STAT_ZERO_FOUND] = zero_found_ff;
			nxt_perr = pwrite_i;
		end else begin
			nxt_perr = 1'b1;
		end
	end

	always @(posedge core_clk_i) begin
		if (rst_i) begin
			prdata_ff <= 32'h0000_0000;
			perr_ff   <= 1'b0;
		end else if (setup_ph) begin
			prdata_ff <= pwrite_i ? 32'h0000_0000 : nxt_prdata;
			perr_ff   <= nxt_perr;
		end
	end

	always @(posedge core_clk_i) begin
		if (rst_i) begin
			disp_sel_ff  <= `FPSD_RST_DISP_SEL;
			show_time_ff <= `FPSD_RST_SHOW_TIME;
			tlim_cond_ff <= 1'b0;
		end else if (wr_en) begin
			if (addr_hit(paddr_i, `FPSD_IDX_DISP_SEL)) begin // see R01
				disp_sel_ff <= wr_merge(disp_sel_ff, pwdata_i, pstrb_i);
			end
			if (addr_hit(paddr_i, `FPSD_IDX_SHOW_TIME)) begin // see R13
				show_time_ff <= (show_time_wr > `FPSD_SHOW_TIME_MAX) ?
					`FPSD_SHOW_TIME_MAX : show_time_wr;
			end
			if (addr_hit(paddr_i, `FPSD_IDX_TLIM_COND) && pstrb_i[0]) begin // see R14
				tlim_cond_ff <= pwdata_i[0];
			end
		end
	end

	// error counters, one per source
	assign err_inc = {ext_enc_comm_err_i, enc_comm_err_i, fieldbus_err_i};

	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_err
			fpsd_sat_cnt #(
				.WIDTH      (CNT_W)
			) u_cnt (
				.core_clk_i (core_clk_i),
				.rst_i      (rst_i),
				.inc_i      (err_inc[gi]),
				.count_o    (err_cnt[gi*CNT_W +: CNT_W])
			); // see R06
		end
	endgenerate

	assign err_fb_cnt  = err_cnt[CNT_W-1:0];
	assign err_enc_cnt = err_cnt[2*CNT_W-1:CNT_W];
	assign err_ext_cnt = err_cnt[3*CNT_W-1:2*CNT_W];

	// rotary switch sync and one-time capture after reset
	always @(posedge core_clk_i) begin
		rot_s1_ff <= rotary_addr_i;
		rot_s2_ff <= rot_s1_ff;
		if (rst_i) begin
			rot_cap_ff   <= 2'h0;
			node_addr_ff <= 8'h00;
		end else if (rot_cap_ff != 2'h3) begin
			rot_cap_ff <= rot_cap_ff + 2'h1;
			if (rot_cap_ff == `FPSD_ROT_CAPTURE_CYC) begin // see R09
				node_addr_ff <= rot_s2_ff;
			end
		end
	end

	// zero position seen since power-on
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			zero_found_ff <= 1'b0;
		end else if (enc_zero_det_i) begin // see R04
			zero_found_ff <= 1'b1;
		end
	end

	// 100 ms steps; end judged per step so a boot-time setting counts
	assign step_tick = (tick_cnt_ff == STEP_LAST);

	always @(posedge core_clk_i) begin
		if (rst_i) begin
			tick_cnt_ff  <= {TICK_W{1'b0}};
			elapsed_ff   <= 11'h000;
			show_done_ff <= 1'b0;
		end else if (!show_done_ff) begin
			tick_cnt_ff <= step_tick ? {TICK_W{1'b0}} : tick_cnt_ff + {{(TICK_W-1){1'b0}}, 1'b1};
			if (step_tick) begin
				elapsed_ff <= elapsed_ff + 11'h001;
				if (({5'h00, elapsed_ff} + 16'h0001) >= show_time_ff) begin // see R16
					show_done_ff <= 1'b1;
				end
			end
		end
	end

	assign addr_show_act = !show_done_ff && ({5'h00, elapsed_ff} < show_time_ff); // see R13

	// decimal digits of the node address
	assign dec_ones = node_addr_ff % 8'd10;
	assign dec_tens = (node_addr_ff % 8'd100) / 8'd10;

	// display selection
	always @* begin
		nxt_seg_hi = `FPSD_SEG_DASH;
		nxt_seg_lo = `FPSD_SEG_DASH;
		if (addr_show_act) begin // see R13
			nxt_seg_hi = seg_hex(dec_tens[3:0]);
			nxt_seg_lo = seg_hex(dec_ones[3:0]);
		end else if (disp_sel_ff < `FPSD_SEL_UNUSED_MIN) begin // see R12
			case (disp_sel_ff[2:0]) // see R01
				`FPSD_SEL_NORMAL: begin
					if (servo_on_i) begin // see R02
						nxt_seg_hi = seg_hex(4'h0);
						nxt_seg_lo = seg_hex(4'h0);
					end
				end
				`FPSD_SEL_MECH: begin
					if (enc_incremental_i && !zero_found_ff) begin // see R04
						nxt_seg_hi = `FPSD_SEG_N;
						nxt_seg_lo = `FPSD_SEG_F;
					end else begin // see R03
						nxt_seg_hi = seg_hex(mech_angle_i[7:4]);
						nxt_seg_lo = seg_hex(mech_angle_i[3:0]);
					end
				end
				`FPSD_SEL_ELEC: begin // see R05
					nxt_seg_hi = seg_hex(elec_angle_i[7:4]);
					nxt_seg_lo = seg_hex(elec_angle_i[3:0]);
				end
				`FPSD_SEL_ERR_FB: begin // see R07
					nxt_seg_hi = seg_hex(err_fb_cnt[7:4]);
					nxt_seg_lo = seg_hex(err_fb_cnt[3:0]);
				end
				`FPSD_SEL_NODE: begin // see R09
					nxt_seg_hi = seg_hex(dec_tens[3:0]);
					nxt_seg_lo = seg_hex(dec_ones[3:0]);
				end
				`FPSD_SEL_ERR_ENC: begin // see R07
					nxt_seg_hi = seg_hex(err_enc_cnt[7:4]);
					nxt_seg_lo = seg_hex(err_enc_cnt[3:0]);
				end
				`FPSD_SEL_ERR_EXT: begin // see R07
					nxt_seg_hi = seg_hex(err_ext_cnt[7:4]);
					nxt_seg_lo = seg_hex(err_ext_cnt[3:0]);
				end
				`FPSD_SEL_ZPHASE: begin
					if (ext_incr_full_closed_i) begin // see R10 R11
						nxt_seg_hi = seg_hex(zphase_cnt_i[7:4]);
						nxt_seg_lo = seg_hex(zphase_cnt_i[3:0]);
					end
				end
				default: nxt_seg_hi = `FPSD_SEG_DASH;
			endcase
		end
	end

	always @(posedge core_clk_i) begin
		if (rst_i) begin
			seg_hi_ff <= `FPSD_SEG_DASH;
			seg_lo_ff <= `FPSD_SEG_DASH;
			tflag_ff  <= 1'b0;
		end else begin
			seg_hi_ff <= nxt_seg_hi; // see R16
			seg_lo_ff <= nxt_seg_lo;
			tflag_ff  <= torque_ctrl_i &&
				(tlim_cond_ff ? tlim_excl_cmd_i : tlim_incl_cmd_i); // see R15
		end
	end

	assign seg_hi_o            = seg_hi_ff;
	assign seg_lo_o            = seg_lo_ff;
	assign addr_show_o         = addr_show_act;
	assign torque_limit_flag_o = tflag_ff;
endmodule // fpsd_top
`default_nettype wire

// ### fpsd_panel_model.sv
// Purpose: two-digit panel model, turns segment patterns into symbols
// Assumes: segment bits gfedcba, active high
// Notes:   0..15 digit, 10h dash, 11h letter n, 1Fh anything else
`default_nettype none
module fpsd_panel_model (
	input  wire logic [6:0] seg_hi_i,
	input  wire logic [6:0] seg_lo_i,
	output wire logic [4:0] sym_hi_o,
	output wire logic [4:0] sym_lo_o
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] segs [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D,
		7'h07, 7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
	function automatic logic [4:0] dec(input logic [6:0] s);
		dec = 5'h1F;
		if (s === 7'h40) dec = 5'h10;
		if (s === 7'h54) dec = 5'h11;
		for (int i = 0; i < 16; i++) if (s === segs[i]) dec = 5'(i);
	endfunction
	assign sym_hi_o = dec(seg_hi_i);
	assign sym_lo_o = dec(seg_lo_i);
endmodule // fpsd_panel_model
`default_nettype wire

// ### fpsd_chk.sv
// Purpose: port-level checks of the display selector
// Assumes: zero-wait APB, segment bits gfedcba
// Notes:   selection and zero flag tracked from the ports
`default_nettype none
module fpsd_chk (
	input wire logic        core_clk_i,
	input wire logic        rst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [31:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0]  pstrb_i,
	input wire logic        pslverr_o,
	input wire logic        servo_on_i,
	input wire logic [7:0]  mech_angle_i,
	input wire logic [7:0]  elec_angle_i,
	input wire logic        enc_incremental_i,
	input wire logic        enc_zero_det_i,
	input wire logic        ext_incr_full_closed_i,
	input wire logic [7:0]  zphase_cnt_i,
	input wire logic        torque_ctrl_i,
	input wire logic        tlim_incl_cmd_i,
	input wire logic        tlim_excl_cmd_i,
	input wire logic [6:0]  seg_hi_o,
	input wire logic [6:0]  seg_lo_o,
	input wire logic        addr_show_o,
	input wire logic        torque_limit_flag_o
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] segs [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D,
		7'h07, 7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
	logic [15:0] sel_ff;
	logic        zero_ff;
	logic [2:0]  up_ff;
	logic        show_q_ff;
	logic        show_end_ff;
	wire         live = (up_ff == 3'h7) && !addr_show_o;
	wire  [13:0] disp = {seg_hi_o, seg_lo_o};
	function automatic logic [13:0] hx(input logic [7:0] v);
		return {segs[v[7:4]], segs[v[3:0]]};
	endfunction
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			sel_ff <= 16'h0000;
			zero_ff <= 1'b0;
			up_ff <= 3'h0;
		end else begin
			if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
			if (enc_zero_det_i) zero_ff <= 1'b1;
			if (psel_i && penable_i && pwrite_i && paddr_i == 32'h0000DC00) begin
				if (pstrb_i[0]) sel_ff[7:0] <= pwdata_i[7:0];
				if (pstrb_i[1]) sel_ff[15:8] <= pwdata_i[15:8];
			end
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			show_q_ff <= 1'b0;
			show_end_ff <= 1'b0;
		end else begin
			show_q_ff <= addr_show_o;
			if (show_q_ff && !addr_show_o) show_end_ff <= 1'b1;
		end
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_unfixed_wait;
		live && sel_ff == 16'h1 && enc_incremental_i && !zero_ff && !enc_zero_det_i;
	endsequence
	sequence s_bad_wr;
		psel_i && !penable_i && pwrite_i && paddr_i >= 32'h0000DC40 ##1 psel_i && penable_i;
	endsequence
	property p_servo;
		live && sel_ff == 16'h0 |=> disp == ($past(servo_on_i) ? 14'h1FBF : 14'h2040);
	endproperty
	a_servo: assert property (p_servo) else $error("servo item wrong");
	property p_mech;
		live && sel_ff == 16'h1 && (!enc_incremental_i || zero_ff) |=> disp == hx($past(mech_angle_i));
	endproperty
	a_mech: assert property (p_mech) else $error("mech angle wrong");
	property p_unfixed;
		s_unfixed_wait |=> disp == 14'h2A71;
	endproperty
	a_unfixed: assert property (p_unfixed) else $error("not fixed pattern wrong");
	property p_elec;
		live && sel_ff == 16'h2 |=> disp == hx($past(elec_angle_i));
	endproperty
	a_elec: assert property (p_elec) else $error("elec angle wrong");
	property p_zph;
		live && sel_ff == 16'h7 && ext_incr_full_closed_i |=> disp == hx($past(zphase_cnt_i));
	endproperty
	a_zph: assert property (p_zph) else $error("z count wrong");
	property p_tq_off;
		!torque_ctrl_i |=> !torque_limit_flag_o;
	endproperty
	a_tq_off: assert property (p_tq_off) else $error("flag outside torque control");
	property p_tq_same;
		torque_ctrl_i && tlim_incl_cmd_i == tlim_excl_cmd_i |=>
			torque_limit_flag_o == $past(tlim_incl_cmd_i);
	endproperty
	a_tq_same: assert property (p_tq_same) else $error("flag wrong");
	property p_bad_wr;
		s_bad_wr |-> pslverr_o;
	endproperty
	a_bad_wr: assert property (p_bad_wr) else $error("counter write accepted");
	property p_show_once;
		show_end_ff |-> !addr_show_o;
	endproperty
	a_show_once: assert property (p_show_once) else $error("address show restarted");
endmodule // fpsd_chk
bind fpsd_top fpsd_chk i_chk (.*);
`default_nettype wire

// ### front_panel_status_display_select_test.sv
// Purpose: self-checking bench for the display selector
// Assumes: zero-wait APB, step shortened to 10 cycles
// Notes:   panel model decodes both digits
`include "fpsd_defines.vh"
`default_nettype none
module front_panel_status_display_select_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i, rst_i, psel_i, penable_i, pwrite_i, servo_on_i, enc_incremental_i;
	logic enc_zero_det_i, fieldbus_err_i, enc_comm_err_i, ext_enc_comm_err_i, er;
	logic ext_incr_full_closed_i, torque_ctrl_i, tlim_incl_cmd_i, tlim_excl_cmd_i;
	logic pready_o, pslverr_o, addr_show_o, torque_limit_flag_o;
	logic [31:0] paddr_i, pwdata_i, prdata_o, rd;
	logic [7:0]  mech_angle_i, elec_angle_i, rotary_addr_i, zphase_cnt_i;
	logic [6:0]  seg_hi_o, seg_lo_o;
	logic [4:0]  sym_hi, sym_lo;
	logic [3:0]  pstrb_i;
	int          miscompares, check_count;
	localparam logic [15:0] errs [3] = '{16'hFFFF, 16'h0102, 16'h0003};
	localparam logic [31:0] esel [3] = '{32'h3, 32'h5, 32'h6};
	fpsd_top #(.STEP_CYCLES(10)) i_dut (.*);
	fpsd_panel_model i_panel (.seg_hi_i(seg_hi_o), .seg_lo_i(seg_lo_o), .sym_hi_o(sym_hi),
		.sym_lo_o(sym_lo));
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
		@(posedge core_clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= {14'h0, idx, 2'b00};
		pwdata_i <= wd;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		do @(posedge core_clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task dchk(input string nm, input logic [4:0] h, input logic [4:0] l);
		repeat (3) @(posedge core_clk_i);
		#1;
		chk(nm, {sym_hi, sym_lo}, {h, l});
		@(posedge core_clk_i);
	endtask
	task t_regs;
		apb(1'b0, `FPSD_IDX_SHOW_TIME, 32'h0);
		chk("show_rst", rd, 32'h0);
		apb(1'b0, `FPSD_IDX_TLIM_COND, 32'h0);
		chk("tlim_rst", rd, 32'h0);
		apb(1'b1, `FPSD_IDX_SHOW_TIME, 32'h1234);
		apb(1'b0, `FPSD_IDX_SHOW_TIME, 32'h0);
		chk("show_max", rd, 32'h3E8);
		chk("addr_show", addr_show_o, 1'b0);
		apb(1'b1, `FPSD_IDX_ERR_FB, 32'h0);
		chk("ro_err", er, 1'b1);
		apb(1'b0, 16'h3702, 32'h0);
		chk("gap_err", er, 1'b1);
		chk("gap_data", rd, 32'h0);
	endtask
	task t_disp;
		dchk("servo_off", 5'h10, 5'h10);
		servo_on_i <= 1'b1;
		dchk("servo_on", 5'h0, 5'h0);
		apb(1'b1, `FPSD_IDX_DISP_SEL, 32'h1);
		dchk("not_fixed", 5'h11, 5'hF);
		enc_zero_det_i <= 1'b1;
		@(posedge core_clk_i);
		enc_zero_det_i <= 1'b0;
		dchk("mech", 5'h3, 5'hA);
		mech_angle_i <= 8'hE1;
		dchk("mech_new", 5'hE, 5'h1);
		apb(1'b1, `FPSD_IDX_DISP_SEL, 32'h2);
		dchk("elec", 5'hC, 5'h4);
		apb(1'b1, `FPSD_IDX_DISP_SEL, 32'h4);
		dchk("node", 5'h5, 5'h8);
		apb(1'b1, `FPSD_IDX_DISP_SEL, 32'h7);
		dchk("zcount", 5'hB, 5'h2);
		ext_incr_full_closed_i <= 1'b0;
		dchk("zcount_off", 5'h10, 5'h10);
		apb(1'b0, `FPSD_IDX_STATUS, 32'h0);
		chk("status", rd[9:0], 10'h23A);
	endtask
	task t_tq;
		for (int i = 0; i < 16; i++) begin
			apb(1'b1, `FPSD_IDX_TLIM_COND, 32'(i[3]));
			torque_ctrl_i <= i[2];
			tlim_incl_cmd_i <= i[1];
			tlim_excl_cmd_i <= i[0];
			repeat (2) @(posedge core_clk_i);
			#1;
			chk("tq_flag", torque_limit_flag_o, i[2] & (i[3] ? i[0] : i[1]));
		end
		apb(1'b0, `FPSD_IDX_TLIM_COND, 32'h0);
		chk("tlim_rd", rd, 32'h1);
	endtask
	task t_erd;
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, 16'(`FPSD_IDX_ERR_FB + i), 32'h0);
			chk("err_cnt", rd, {16'h0, errs[i]});
			apb(1'b1, `FPSD_IDX_DISP_SEL, esel[i]);
			dchk("err_low", {1'b0, errs[i][7:4]}, {1'b0, errs[i][3:0]});
		end
	endtask
	task t_err;
		fieldbus_err_i <= 1'b1;
		repeat (65540) @(posedge core_clk_i);
		fieldbus_err_i <= 1'b0;
		enc_comm_err_i <= 1'b1;
		repeat (258) @(posedge core_clk_i);
		enc_comm_err_i <= 1'b0;
		ext_enc_comm_err_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		ext_enc_comm_err_i <= 1'b0;
		t_erd;
	endtask
	task t_show;
		rst_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		rst_i <= 1'b0;
		apb(1'b1, `FPSD_IDX_SHOW_TIME, 32'h2);
		#1;
		chk("show_on", addr_show_o, 1'b1);
		apb(1'b0, `FPSD_IDX_ERR_FB, 32'h0);
		chk("err_clr", rd, 32'h0);
		#1;
		chk("show_node", {sym_hi, sym_lo}, {5'h2, 5'h1});
		repeat (13) @(posedge core_clk_i);
		#1;
		chk("show_hold", addr_show_o, 1'b1);
		@(posedge core_clk_i);
		#1;
		chk("show_end", addr_show_o, 1'b0);
		dchk("show_after", 5'h0, 5'h0);
	endtask
	task summarize;
		if (miscompares == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		{psel_i, penable_i, pwrite_i, servo_on_i, enc_zero_det_i, fieldbus_err_i} = '0;
		{enc_comm_err_i, ext_enc_comm_err_i, torque_ctrl_i, tlim_incl_cmd_i, tlim_excl_cmd_i} = '0;
		{enc_incremental_i, ext_incr_full_closed_i, rst_i} = 3'b111;
		{paddr_i, pwdata_i, pstrb_i} = {64'h0, 4'hF};
		{mech_angle_i, elec_angle_i, zphase_cnt_i, rotary_addr_i} = 32'h3AC4B23A;
		miscompares = 0;
		check_count = 0;
		repeat (4) @(posedge core_clk_i);
		rst_i <= 1'b0;
		repeat (5) @(posedge core_clk_i);
		rotary_addr_i <= 8'h15;
		t_regs;
		t_disp;
		t_tq;
		t_err;
		t_erd;
		t_show;
		summarize;
	end
	initial begin
		#900000;
		miscompares++;
		summarize;
	end
endmodule // front_panel_status_display_select_test
`default_nettype wire
